// ===== hw/acl_port.sv
// device end of the serial codec link, with strap capture and receive buffer
`timescale 1ns/1ps

module acl_port (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst,
    input  wire logic                       i_link_clk,
    input  wire logic                       i_power_good,
    input  wire logic                       i_codec_reset_req,
    input  wire logic                       i_high_rate,
    input  wire logic                       i_frame_sync,
    input  wire logic                       i_serial_out_to_codec,
    input  wire logic [acl_pkg::LANES-1:0]  i_serial_in_from_codecs,
    input  wire logic                       i_tx_valid,
    input  wire logic [acl_pkg::WORD_W-1:0] i_tx_data,
    input  wire logic [acl_pkg::STREAM_W-1:0] i_tx_stream,
    input  wire logic                       i_rx_ready,
    output logic                            o_codec_reset_n,
    output logic                            o_frame_sync,
    output logic                            o_frame_sync_oe,
    output logic                            o_serial_out_to_codec,
    output logic                            o_serial_out_oe,
    output logic                            o_serial_bit_clock,
    output logic                            o_serial_bit_clock_oe,
    output logic                            o_wide_lanes,
    output logic                            o_tx_ready,
    output logic                            o_rx_valid,
    output logic [acl_pkg::RX_W-1:0]        o_rx_data,
    output logic                            o_rx_overrun
);

    // ----------------------------------------------------------------
    // power good, straps and codec reset (main clock)
    // ----------------------------------------------------------------
    logic pg_s1_q;
    logic pg_s2_q;
    logic pg_s3_q;
    logic fs_s1_q;
    logic fs_s2_q;
    logic so_s1_q;
    logic so_s2_q;
    logic pg_rise;

    assign pg_rise = pg_s2_q & ~pg_s3_q;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            {pg_s1_q, pg_s2_q, pg_s3_q} <= 3'h0;
            {fs_s1_q, fs_s2_q, so_s1_q, so_s2_q} <= 4'h0;
            o_codec_reset_n <= 1'b0;
            o_wide_lanes    <= 1'b0;
        end
        else
        begin
            {pg_s1_q, pg_s2_q, pg_s3_q} <= {i_power_good, pg_s1_q, pg_s2_q};
            {fs_s1_q, fs_s2_q, so_s1_q, so_s2_q} <= {i_frame_sync, fs_s1_q, i_serial_out_to_codec, so_s1_q};
            o_codec_reset_n <= pg_s2_q & ~i_codec_reset_req;
            // pins are undriven until codec reset lifts, so the straps read the pull resistors
            if (pg_rise)
                o_wide_lanes <= fs_s2_q & so_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // link timing (link clock)
    // ----------------------------------------------------------------
    logic                            run_s1_q;
    logic                            run_s2_q;
    logic                            hr_s1_q;
    logic                            hr_s2_q;
    acl_pkg::acl_mode_t              mode_q;
    logic [acl_pkg::CNT_W-1:0]       cnt_q;
    logic [acl_pkg::WORD_W-1:0]      sh_q;
    logic [acl_pkg::STREAM_W-1:0]    stream_q;
    logic [acl_pkg::RX_W-1:0]        rx_sh_q;
    logic                            rx_done_q;
    logic                            hr;
    logic                            wrap;
    logic                            tx_win;
    logic                            rx_win;
    logic                            rx_last;
    logic [acl_pkg::CNT_W-1:0]       rx_end;
    logic                            sync_d;
    logic                            tx_dv;
    logic [acl_pkg::TX_W-1:0]        tx_word;
    logic                            rx_src_ready;

    assign hr      = (mode_q == acl_pkg::ACL_MODE_HIGH);
    assign wrap    = ~run_s2_q | (cnt_q == (hr ? acl_pkg::LAST_HR : acl_pkg::LAST_LEG));
    assign tx_win  = run_s2_q & (cnt_q >= acl_pkg::DATA_START) & (cnt_q <= acl_pkg::TX_END);
    assign rx_end  = hr ? acl_pkg::RX_END_HR : acl_pkg::RX_END_LEG;
    // high rate samples on odd counts only: one sample per bit time
    assign rx_win  = run_s2_q & (cnt_q >= acl_pkg::DATA_START) & (cnt_q <= rx_end) & (~hr | cnt_q[0]);
    assign rx_last = rx_win & (cnt_q == rx_end);
    // stream number goes out msb first, two link clocks per bit
    assign sync_d  = run_s2_q & (hr ? ((cnt_q < acl_pkg::SYNC_HR_END) |
                                       ((cnt_q < acl_pkg::STREAM_END) & stream_q[~cnt_q[2:1]]))
                                    : (cnt_q < acl_pkg::SYNC_LEG_END));

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            {run_s1_q, run_s2_q, hr_s1_q, hr_s2_q} <= 4'h0;
            mode_q   <= acl_pkg::ACL_MODE_LEGACY;
            cnt_q    <= acl_pkg::CNT_RST;
        end
        else
        begin
            {run_s1_q, run_s2_q, hr_s1_q, hr_s2_q} <= {o_codec_reset_n, run_s1_q, i_high_rate, hr_s1_q};
            // mode changes only between frames so no frame is cut short
            if (wrap)
            begin
                cnt_q  <= acl_pkg::CNT_RST;
                mode_q <= hr_s2_q ? acl_pkg::ACL_MODE_HIGH : acl_pkg::ACL_MODE_LEGACY;
            end
            else
                cnt_q <= cnt_q + 10'h001;
        end
    end

    // ----------------------------------------------------------------
    // link pins (link clock)
    // ----------------------------------------------------------------
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sh_q                  <= '0;
            stream_q              <= '0;
            o_frame_sync          <= 1'b0;
            o_frame_sync_oe       <= 1'b0;
            o_serial_out_to_codec <= 1'b0;
            o_serial_out_oe       <= 1'b0;
            o_serial_bit_clock    <= 1'b0;
            o_serial_bit_clock_oe <= 1'b0;
        end
        else
        begin
            // a frame without a queued word sends zeros and stream zero
            if (wrap)
                {stream_q, sh_q} <= tx_dv ? tx_word : '0;
            else if (tx_win)
                sh_q <= {sh_q[acl_pkg::WORD_W-2:0], 1'b0};
            o_frame_sync          <= sync_d;
            o_frame_sync_oe       <= run_s2_q;
            o_serial_out_to_codec <= tx_win & sh_q[acl_pkg::WORD_W-1];
            o_serial_out_oe       <= run_s2_q;
            o_serial_bit_clock    <= run_s2_q & hr & ~o_serial_bit_clock;
            o_serial_bit_clock_oe <= run_s2_q & hr;
        end
    end

    // ----------------------------------------------------------------
    // receive capture, one shift register per codec lane
    // ----------------------------------------------------------------
    genvar l;
    generate
        for (l = 0; l < acl_pkg::LANES; l++)
        begin : g_lane
            always_ff @(posedge i_link_clk or posedge i_rst)
            begin
                if (i_rst)
                    rx_sh_q[l*acl_pkg::WORD_W +: acl_pkg::WORD_W] <= '0;
                else if (rx_win)
                    rx_sh_q[l*acl_pkg::WORD_W +: acl_pkg::WORD_W] <=
                        {rx_sh_q[l*acl_pkg::WORD_W +: acl_pkg::WORD_W-1], i_serial_in_from_codecs[l]};
            end
        end
    endgenerate

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_done_q    <= 1'b0;
            o_rx_overrun <= 1'b0;
        end
        else
        begin
            rx_done_q <= rx_last;
            // the codecs cannot be stalled, so a frame that finds the crossing busy is lost
            if (rx_done_q & ~rx_src_ready)
                o_rx_overrun <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // clock domain crossings
    // ----------------------------------------------------------------
    logic                     rx_mv;
    logic [acl_pkg::RX_W-1:0] rx_mword;
    logic                     buf_in_ready;

    acl_xfer #(.W(acl_pkg::TX_W)) u_tx_xfer (
        .i_rst       (i_rst),
        .i_src_clk   (i_mclk),
        .i_src_valid (i_tx_valid),
        .o_src_ready (o_tx_ready),
        .i_src_data  ({i_tx_stream, i_tx_data}),
        .i_dst_clk   (i_link_clk),
        .o_dst_valid (tx_dv),
        .i_dst_ready (wrap),
        .o_dst_data  (tx_word)
    );

    acl_xfer #(.W(acl_pkg::RX_W)) u_rx_xfer (
        .i_rst       (i_rst),
        .i_src_clk   (i_link_clk),
        .i_src_valid (rx_done_q),
        .o_src_ready (rx_src_ready),
        .i_src_data  (rx_sh_q),
        .i_dst_clk   (i_mclk),
        .o_dst_valid (rx_mv),
        .i_dst_ready (buf_in_ready),
        .o_dst_data  (rx_mword)
    );

    // ----------------------------------------------------------------
    // two-entry receive buffer, head always at index 0
    // ----------------------------------------------------------------
    logic [acl_pkg::RX_W-1:0]      mem_q [0:1];
    logic [acl_pkg::BUF_CNT_W-1:0] cnt_buf_q;
    logic [acl_pkg::BUF_CNT_W-1:0] cnt_buf_d;
    logic                          push;
    logic                          pop;

    assign buf_in_ready = (cnt_buf_q != acl_pkg::BUF_DEPTH);
    assign push         = rx_mv & buf_in_ready;
    assign pop          = o_rx_valid & i_rx_ready;
    assign cnt_buf_d    = cnt_buf_q + {1'b0, push} - {1'b0, pop};
    assign o_rx_data    = mem_q[0];

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_q[0]   <= '0;
            mem_q[1]   <= '0;
            cnt_buf_q  <= '0;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            cnt_buf_q  <= cnt_buf_d;
            o_rx_valid <= (cnt_buf_d != '0);
            if (pop)
                mem_q[0] <= (push & (cnt_buf_q == 2'h1)) ? rx_mword : mem_q[1];
            if (push & (~pop | (cnt_buf_q == acl_pkg::BUF_DEPTH)))
                mem_q[pop ? 1'b1 : cnt_buf_q[0]] <= rx_mword;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_codec_rst;
        @(posedge i_mclk) disable iff (i_rst)
        (~pg_s2_q | i_codec_reset_req) |=> ~o_codec_reset_n;
    endproperty
    a_codec_rst: assert property (p_codec_rst)
        else $error("codec reset released while power good low or reset requested");

    property p_strap_cap;
        @(posedge i_mclk) disable iff (i_rst)
        pg_rise |=> (o_wide_lanes == $past(fs_s2_q & so_s2_q));
    endproperty
    a_strap_cap: assert property (p_strap_cap)
        else $error("lane strap not captured at power good rise");

    property p_strap_hold;
        @(posedge i_mclk) disable iff (i_rst)
        ~pg_rise |=> $stable(o_wide_lanes);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("lane strap changed without a power good rise");

    property p_frame_len;
        @(posedge i_link_clk) disable iff (i_rst)
        (run_s2_q & ~hr & (cnt_q == acl_pkg::LAST_LEG)) |=> (cnt_q == acl_pkg::CNT_RST);
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("legacy frame length wrong");

    property p_sync_width;
        @(posedge i_link_clk) disable iff (i_rst)
        (run_s2_q & ~hr & (cnt_q == acl_pkg::CNT_RST) & $past(run_s2_q)) |=> (o_frame_sync | ~run_s2_q) [*8];
    endproperty
    a_sync_width: assert property (p_sync_width)
        else $error("legacy frame sync too short");

    property p_stream_bit;
        @(posedge i_link_clk) disable iff (i_rst)
        (run_s2_q & hr & (cnt_q == acl_pkg::SYNC_HR_END)) |=> (o_frame_sync == stream_q[3]) [*2];
    endproperty
    a_stream_bit: assert property (p_stream_bit)
        else $error("stream number msb not on frame sync");

    property p_bclk;
        @(posedge i_link_clk) disable iff (i_rst)
        (run_s2_q & hr & $past(run_s2_q & hr)) |=> (o_serial_bit_clock != $past(o_serial_bit_clock));
    endproperty
    a_bclk: assert property (p_bclk)
        else $error("high rate bit clock not toggling");

    property p_bclk_oe;
        @(posedge i_link_clk) disable iff (i_rst)
        ~hr |=> ~o_serial_bit_clock_oe;
    endproperty
    a_bclk_oe: assert property (p_bclk_oe)
        else $error("bit clock driven in legacy mode");

    property p_sdout;
        @(posedge i_link_clk) disable iff (i_rst)
        tx_win |=> (o_serial_out_to_codec == $past(sh_q[acl_pkg::WORD_W-1]));
    endproperty
    a_sdout: assert property (p_sdout)
        else $error("serial out does not follow shift register");

    property p_rx_phase;
        @(posedge i_link_clk) disable iff (i_rst)
        (hr & rx_win) |=> ~rx_win;
    endproperty
    a_rx_phase: assert property (p_rx_phase)
        else $error("high rate input sampled twice in one bit");

endmodule

// ===== hw/acl_pkg.sv
// constants and types shared by the codec link port
package acl_pkg;

    // ----------------------------------------------------------------
    // clock rates and frame timing
    // ----------------------------------------------------------------
    localparam int MCLK_HZ     = 20_000_000;
    localparam int FRAME_HZ    = 48_000;
    localparam int LEG_BCLK_HZ = 12_288_000;
    localparam int HR_BCLK_HZ  = 24_000_000;

    // legacy: link clock is the bit clock; high rate: link clock runs at twice the bit clock
    localparam int FRAME_LEG_CLKS = LEG_BCLK_HZ / FRAME_HZ;
    localparam int FRAME_HR_CLKS  = (2 * HR_BCLK_HZ) / FRAME_HZ;

    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] LAST_LEG     = CNT_W'(FRAME_LEG_CLKS - 1);
    localparam logic [CNT_W-1:0] LAST_HR      = CNT_W'(FRAME_HR_CLKS - 1);
    localparam logic [CNT_W-1:0] CNT_RST      = 10'h000;

    // ----------------------------------------------------------------
    // frame layout, in link clocks from the frame start
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] SYNC_LEG_END = 10'h010;
    localparam logic [CNT_W-1:0] SYNC_HR_END  = 10'h008;
    localparam logic [CNT_W-1:0] STREAM_END   = 10'h010;
    localparam logic [CNT_W-1:0] DATA_START   = 10'h010;
    localparam logic [CNT_W-1:0] TX_END       = 10'h01F;
    localparam logic [CNT_W-1:0] RX_END_LEG   = 10'h01F;
    localparam logic [CNT_W-1:0] RX_END_HR    = 10'h02F;

    // ----------------------------------------------------------------
    // data widths
    // ----------------------------------------------------------------
    localparam int WORD_W   = 16;
    localparam int STREAM_W = 4;
    localparam int LANES    = 3;
    localparam int RX_W     = WORD_W * LANES;
    localparam int TX_W     = WORD_W + STREAM_W;
    localparam int BUF_CNT_W = 2;
    localparam logic [BUF_CNT_W-1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [1:0]
    {
        ACL_MODE_LEGACY = 2'b01,
        ACL_MODE_HIGH   = 2'b10
    } acl_mode_t;

endpackage

// ===== hw/acl_xfer.sv
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps

module acl_xfer #(
    parameter int W = 16
) (
    input  wire logic         i_rst,
    input  wire logic         i_src_clk,
    input  wire logic         i_src_valid,
    output logic              o_src_ready,
    input  wire logic [W-1:0] i_src_data,
    input  wire logic         i_dst_clk,
    output logic              o_dst_valid,
    input  wire logic         i_dst_ready,
    output logic [W-1:0]      o_dst_data
);

    // ----------------------------------------------------------------
    // source side
    // ----------------------------------------------------------------
    logic         req_q;
    logic         ack_s1_q;
    logic         ack_s2_q;
    logic         ack_toggle_q;
    logic [W-1:0] data_q;
    logic         load;
    logic         busy_d;

    // source word is held in data_q, so it stays stable until the far side toggles back
    assign load   = i_src_valid & o_src_ready;
    assign busy_d = load | (~o_src_ready & (ack_s2_q != req_q));

    always_ff @(posedge i_src_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_q       <= 1'b0;
            ack_s1_q    <= 1'b0;
            ack_s2_q    <= 1'b0;
            data_q      <= '0;
            o_src_ready <= 1'b1;
        end
        else
        begin
            ack_s1_q    <= ack_toggle_q;
            ack_s2_q    <= ack_s1_q;
            o_src_ready <= ~busy_d;
            if (load)
            begin
                req_q  <= ~req_q;
                data_q <= i_src_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // destination side
    // ----------------------------------------------------------------
    logic req_s1_q;
    logic req_s2_q;

    always_ff @(posedge i_dst_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_s1_q     <= 1'b0;
            req_s2_q     <= 1'b0;
            ack_toggle_q <= 1'b0;
            o_dst_valid  <= 1'b0;
            o_dst_data   <= '0;
        end
        else
        begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            if (o_dst_valid & i_dst_ready)
            begin
                o_dst_valid  <= 1'b0;
                ack_toggle_q <= req_s2_q;
            end
            else if (~o_dst_valid & (req_s2_q != ack_toggle_q))
            begin
                o_dst_valid <= 1'b1;
                o_dst_data  <= data_q;
            end
        end
    end

endmodule

// ===== sim/acl_codec_model.sv
// behavioural group of codecs at the far end of the link
`timescale 1ns/1ps

module acl_codec_model (
    output logic            o_link_clk,
    input  wire logic       i_frame_sync,
    input  wire logic       i_frame_sync_oe,
    input  wire logic       i_serial_out,
    input  wire logic       i_serial_out_oe,
    input  wire logic       i_bit_clock,
    input  wire logic       i_codec_reset_n,
    input  wire logic [2:0] i_lane_level,
    output logic [2:0]      o_serial_in,
    output logic [15:0]     o_word,
    output logic [3:0]      o_stream,
    output int              o_words,
    output int              o_frames,
    output int              o_frame_len,
    output int              o_bclk_rises
);
    int          k;
    int          rises;
    logic        sync_q;
    logic        bclk_q;
    logic [15:0] word_sr;
    logic [3:0]  stream_sr;
    logic        sync_in;
    logic        sdo_in;

    // ----------------------------------------------------------------
    // link clock: free running, like a crystal-fed codec
    // ----------------------------------------------------------------
    initial
    begin
        {o_words, o_frames, o_frame_len, o_bclk_rises, rises} = '0;
        {sync_q, bclk_q, word_sr, stream_sr, o_word, o_stream} = '0;
        k = 2000;
        o_serial_in = 3'h0;
        o_link_clk = 1'b0;
        #13;
        forever #40 o_link_clk = ~o_link_clk;
    end

    // an undriven pin reads as low here, so a missing enable shows as a wrong word
    assign sync_in = i_frame_sync & i_frame_sync_oe;
    assign sdo_in  = i_serial_out & i_serial_out_oe;

    // lanes move on the falling edge; held in reset they show the inverse level
    always @(negedge o_link_clk)
        o_serial_in <= i_codec_reset_n ? i_lane_level : ~i_lane_level;

    // ----------------------------------------------------------------
    // frame watcher
    // ----------------------------------------------------------------
    always @(posedge o_link_clk)
    begin
        sync_q <= sync_in;
        bclk_q <= i_bit_clock;
        rises  <= rises + ((i_bit_clock && !bclk_q) ? 1 : 0);
        k      <= (k < 2000) ? k + 1 : k;
        // stream bits can raise sync again, so only a late rise opens a frame
        if (sync_in && !sync_q && k > 40)
        begin
            k            <= 1;
            o_frames     <= o_frames + 1;
            o_frame_len  <= k;
            o_bclk_rises <= rises;
            rises        <= (i_bit_clock && !bclk_q) ? 1 : 0;
        end
        else
        begin
            if (k >= 16 && k <= 31)
                word_sr <= {word_sr[14:0], sdo_in};
            if (k == 31)
            begin
                o_word  <= {word_sr[14:0], sdo_in};
                o_words <= o_words + 1;
            end
            if (k inside {8, 10, 12, 14})
                stream_sr <= {stream_sr[2:0], sync_in};
            if (k == 14)
                o_stream <= {stream_sr[2:0], sync_in};
        end
    end
endmodule

// ===== sim/tb_acl_port.sv
// self-checking bench for the codec link port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module tb_acl_port;
    typedef struct { logic hr; logic [15:0] word; logic [3:0] stream; logic [2:0] lanes; int len; } acl_row_t;
    acl_row_t rows [4] = '{'{1'b0, 16'hA5C3, 4'h0, 3'h5, 256}, '{1'b1, 16'h8001, 4'hB, 3'h2, 1000},
                           '{1'b1, 16'h7FFE, 4'h6, 3'h7, 1000}, '{1'b0, 16'hFFFF, 4'h0, 3'h0, 256}};
    logic i_mclk, i_rst, i_link_clk, i_power_good, i_codec_reset_req, i_high_rate, i_tx_valid, i_rx_ready;
    logic [15:0] i_tx_data;
    logic [3:0]  i_tx_stream;
    logic [2:0]  i_serial_in_from_codecs, lanes;
    logic o_codec_reset_n, o_frame_sync, o_frame_sync_oe, o_serial_out_to_codec, o_serial_out_oe;
    logic o_serial_bit_clock, o_serial_bit_clock_oe, o_wide_lanes, o_tx_ready, o_rx_valid, o_rx_overrun;
    logic [47:0] o_rx_data;
    logic fs_pull, so_pull, fs_pin, so_pin;
    logic [15:0] tx_word;
    logic [3:0]  tx_stream;
    int words, frames, frame_len, bclk_rises, target, failures, samples_checked;

    // ----------------------------------------------------------------
    // pins: strap pull-ups win only while the device is not driving
    // ----------------------------------------------------------------
    assign fs_pin = o_frame_sync_oe ? o_frame_sync : fs_pull;
    assign so_pin = o_serial_out_oe ? o_serial_out_to_codec : so_pull;

    acl_port dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_power_good(i_power_good),
        .i_codec_reset_req(i_codec_reset_req), .i_high_rate(i_high_rate), .i_frame_sync(fs_pin),
        .i_serial_out_to_codec(so_pin), .i_serial_in_from_codecs(i_serial_in_from_codecs),
        .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .i_tx_stream(i_tx_stream), .i_rx_ready(i_rx_ready),
        .o_codec_reset_n(o_codec_reset_n), .o_frame_sync(o_frame_sync), .o_frame_sync_oe(o_frame_sync_oe),
        .o_serial_out_to_codec(o_serial_out_to_codec), .o_serial_out_oe(o_serial_out_oe),
        .o_serial_bit_clock(o_serial_bit_clock), .o_serial_bit_clock_oe(o_serial_bit_clock_oe),
        .o_wide_lanes(o_wide_lanes), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
        .o_rx_data(o_rx_data), .o_rx_overrun(o_rx_overrun));

    acl_codec_model codec (.o_link_clk(i_link_clk), .i_frame_sync(o_frame_sync), .i_frame_sync_oe(o_frame_sync_oe),
        .i_serial_out(o_serial_out_to_codec), .i_serial_out_oe(o_serial_out_oe), .i_bit_clock(o_serial_bit_clock),
        .i_codec_reset_n(o_codec_reset_n), .i_lane_level(lanes), .o_serial_in(i_serial_in_from_codecs),
        .o_word(tx_word), .o_stream(tx_stream), .o_words(words), .o_frames(frames), .o_frame_len(frame_len),
        .o_bclk_rises(bclk_rises));

    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    initial
    begin
        #5_000_000;
        failures++;
        $display("[ERR] run expected end seen timeout");
        conclude();
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: return o_tx_ready === 1'b1;
            1: return o_rx_valid === 1'b1;
            2: return frames >= target;
            default: return words >= target;
        endcase
    endfunction

    // bounded so a silent link ends the run instead of hanging it
    task automatic wait_for(input int sel);
        int t;
        t = 0;
        while (!probe(sel) && t < 8000)
        begin
            tick(1);
            t++;
        end
        if (t >= 8000)
        begin
            failures++;
            $display("[ERR] wait %0d expected done seen timeout", sel);
            conclude();
        end
    endtask

    task automatic send(input logic [15:0] w, input logic [3:0] s);
        wait_for(0);
        i_tx_data   = w;
        i_tx_stream = s;
        i_tx_valid  = 1'b1;
        tick(1);
        i_tx_valid = 1'b0;
        tick(1);
        wait_for(0);
        target = words + 1;
        wait_for(3);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {i_rst, fs_pull, so_pull, i_rx_ready} = 4'hF;
        {i_power_good, i_codec_reset_req, i_high_rate, i_tx_valid} = 4'h0;
        i_tx_data = 16'h0000;
        i_tx_stream = 4'h0;
        lanes = 3'h0;
        {failures, samples_checked, target} = '0;
        tick(8);
        i_rst = 1'b0;
        tick(4);
        `CHK("codec_reset_n", 1'b0, o_codec_reset_n)
        i_power_good = 1'b1;
        tick(6);
        `CHK("codec_reset_n", 1'b1, o_codec_reset_n)
        `CHK("wide_lanes", 1'b1, o_wide_lanes)
        for (int r = 0; r < 4; r++)
        begin
            i_high_rate = rows[r].hr;
            lanes = rows[r].lanes;
            target = frames + 3;
            wait_for(2);
            `CHK("frame_len", rows[r].len, frame_len)
            `CHK("bit_clock_oe", rows[r].hr, o_serial_bit_clock_oe)
            if (rows[r].hr)
                `CHK("bit_clock_rises", 500, bclk_rises)
            send(rows[r].word, rows[r].stream);
            `CHK("tx_word", rows[r].word, tx_word)
            if (rows[r].hr)
                `CHK("tx_stream", rows[r].stream, tx_stream)
            wait_for(1);
            `CHK("rx_data", {{16{rows[r].lanes[2]}}, {16{rows[r].lanes[1]}}, {16{rows[r].lanes[0]}}}, o_rx_data)
            $display("test row %0d done", r);
        end
        // a receiver that stalls fills the buffer, then frames are dropped
        lanes = 3'h6;
        target = frames + 1;
        wait_for(2);
        i_rx_ready = 1'b0;
        target = frames + 5;
        wait_for(2);
        `CHK("rx_overrun", 1'b1, o_rx_overrun)
        `CHK("rx_data", {{16{1'b1}}, {16{1'b1}}, {16{1'b0}}}, o_rx_data)
        i_rx_ready = 1'b1;
        tick(1);
        `CHK("rx_valid", 1'b1, o_rx_valid)
        `CHK("rx_data", {{16{1'b1}}, {16{1'b1}}, {16{1'b0}}}, o_rx_data)
        $display("test overrun done");
        i_codec_reset_req = 1'b1;
        tick(4);
        `CHK("codec_reset_n", 1'b0, o_codec_reset_n)
        i_codec_reset_req = 1'b0;
        tick(4);
        `CHK("codec_reset_n", 1'b1, o_codec_reset_n)
        $display("test codec reset done");
        // each strap case starts from reset so the pins are released at the rise
        for (int s = 0; s < 4; s++)
        begin
            i_rst = 1'b1;
            i_power_good = 1'b0;
            tick(4);
            if (s == 0)
            begin
                `CHK("reset_tx_ready", 1'b1, o_tx_ready)
                `CHK("reset_overrun", 1'b0, o_rx_overrun)
                `CHK("reset_frame_sync_oe", 1'b0, o_frame_sync_oe)
            end
            i_rst = 1'b0;
            fs_pull = s[1];
            so_pull = s[0];
            tick(4);
            `CHK("codec_reset_n", 1'b0, o_codec_reset_n)
            i_power_good = 1'b1;
            tick(6);
            `CHK("wide_lanes", s == 3, o_wide_lanes)
            fs_pull = ~fs_pull;
            so_pull = ~so_pull;
            tick(8);
            `CHK("wide_lanes_held", s == 3, o_wide_lanes)
        end
        $display("test straps done");
        conclude();
    end
endmodule
